// ### src/ict_pkg.sv
// Constants, opcodes and state codes for the instruction cycle core.
// Assumes single-clock use; opcode layout is local to this core.
package ict_pkg;
	// ==========================================================
	// Widths and instruction fields
	localparam int PC_W = 11;
	localparam int INSTR_W = 16;
	localparam int DATA_W = 8;
	localparam int OP_W = 5;
	localparam int OP_LSB = 11;
	localparam int SEL_LSB = 8;
	localparam int SEL_W = 3;
	localparam int DST_BIT = 8;
	localparam int PH_W = 2;
	// ==========================================================
	// Instruction cycle phases, four clocks per cycle
	localparam logic [PH_W-1:0] PH_FIRST = 2'h0;
	localparam logic [PH_W-1:0] PH_READ = 2'h1;
	localparam logic [PH_W-1:0] PH_WRITE = 2'h2;
	localparam logic [PH_W-1:0] PH_LAST = 2'h3;
	// ==========================================================
	// Special addresses and reset values
	localparam logic [DATA_W-1:0] PC_LOW_ADDR = 8'h06;
	localparam logic [PC_W-1:0] PC_RESET = 11'h000;
	localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
	localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
	// ==========================================================
	// Opcodes
	localparam logic [OP_W-1:0] OP_NOP = 5'h00;
	localparam logic [OP_W-1:0] OP_LOAD_A_M = 5'h01;
	localparam logic [OP_W-1:0] OP_STORE_M_A = 5'h02;
	localparam logic [OP_W-1:0] OP_LOAD_A_X = 5'h03;
	localparam logic [OP_W-1:0] OP_ADD_M = 5'h04;
	localparam logic [OP_W-1:0] OP_ADD_X = 5'h05;
	localparam logic [OP_W-1:0] OP_SUB_M = 5'h06;
	localparam logic [OP_W-1:0] OP_SUB_X = 5'h07;
	localparam logic [OP_W-1:0] OP_AND = 5'h08;
	localparam logic [OP_W-1:0] OP_OR = 5'h09;
	localparam logic [OP_W-1:0] OP_XOR = 5'h0a;
	localparam logic [OP_W-1:0] OP_COMPL = 5'h0b;
	localparam logic [OP_W-1:0] OP_INC = 5'h0c;
	localparam logic [OP_W-1:0] OP_DEC = 5'h0d;
	localparam logic [OP_W-1:0] OP_ROR = 5'h0e;
	localparam logic [OP_W-1:0] OP_ROL = 5'h0f;
	localparam logic [OP_W-1:0] OP_RORC = 5'h10;
	localparam logic [OP_W-1:0] OP_ROLC = 5'h11;
	localparam logic [OP_W-1:0] OP_SET = 5'h12;
	localparam logic [OP_W-1:0] OP_CLR = 5'h13;
	localparam logic [OP_W-1:0] OP_SZ = 5'h14;
	localparam logic [OP_W-1:0] OP_SZ_BIT = 5'h15;
	localparam logic [OP_W-1:0] OP_SNZ_BIT = 5'h16;
	localparam logic [OP_W-1:0] OP_BRANCH = 5'h17;
	localparam logic [OP_W-1:0] OP_CALL = 5'h18;
	localparam logic [OP_W-1:0] OP_EXIT = 5'h19;
	localparam logic [OP_W-1:0] OP_IEXIT = 5'h1a;
	localparam logic [OP_W-1:0] OP_TABRD = 5'h1b;
	localparam logic [OP_W-1:0] OP_IEN_CLR = 5'h1c;
	localparam logic [OP_W-1:0] OP_IEN_SET = 5'h1d;
	// ==========================================================
	// Sequencer states
	typedef enum logic [2:0] {
		ICT_RUN = 3'h1,
		ICT_BUBBLE = 3'h2,
		ICT_TABLE = 3'h4
	} ict_state_type;
endpackage

// ### src/ict_core.sv
// Instruction sequencer and datapath of an 8-bit core.
// Assumes program and data memories answer within two clocks of an address.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Moves, arithmetic, logic, rotates and bit operations finish in one instruction cycle.
// - Jump, call, return, interrupt return and table read take two instruction cycles.
// - One instruction cycle is exactly four system clocks.
// - Writing the program counter low byte jumps there and costs one extra cycle.
// - A taken skip costs one extra cycle, an untaken skip finishes in one.
// - Skips test a memory byte or one bit and then run or bypass the next instruction.
// - A call saves a return point and return resumes right after the call.
// - A jump loads the target without saving any return address.
// - Logic operations set the zero flag when the result is zero.
// - Addition flags a carry above 255, subtraction flags a borrow below 0.
// - Increment and decrement change the operand by one into memory or accumulator.
// - Rotates shift one bit, through-carry forms swap the outgoing bit and the carry.
// - Bit force-high and force-low change only the addressed bit by read-modify-write.
// - Moves cover memory to accumulator, accumulator to memory and immediate load.
// - Table reads fetch fixed program memory data into data registers.
// - Interrupt return sets the global enable, a plain return leaves it alone.
module ict_core #(
	parameter int STACK_DEPTH = 8
) (
	// Clock and reset
	input wire logic clock_in,
	input wire logic rst_n_in,
	// Program memory
	output logic [ict_pkg::PC_W-1:0] prog_addr_out,
	input wire logic [ict_pkg::INSTR_W-1:0] prog_data_in,
	// Data memory
	output logic [ict_pkg::DATA_W-1:0] dmem_addr_out,
	input wire logic [ict_pkg::DATA_W-1:0] dmem_rdata_in,
	output logic [ict_pkg::DATA_W-1:0] dmem_wdata_out,
	output logic dmem_we_out,
	// Core state
	output logic [ict_pkg::DATA_W-1:0] acc_out,
	output logic zero_flag_out,
	output logic carry_flag_out,
	output logic global_interrupt_enable_out,
	output logic [ict_pkg::DATA_W-1:0] table_high_out
);
	import ict_pkg::*;

	localparam int SP_W = $clog2(STACK_DEPTH);

	// ==========================================================
	// Helpers
	function automatic logic [DATA_W-1:0] bit_mask(input logic [SEL_W-1:0] sel);
		bit_mask = DATA_ONE << sel;
	endfunction

	// ==========================================================
	// State
	ict_state_type st_reg, st_next;
	logic [PH_W-1:0] ph_reg, ph_next;
	logic [PC_W-1:0] pc_reg, pc_next, paddr_reg, paddr_next;
	logic [INSTR_W-1:0] ir_reg, ir_next;
	logic [DATA_W-1:0] opnd_reg, opnd_next, acc_reg, acc_next;
	logic [DATA_W-1:0] daddr_reg, daddr_next, wdata_reg, wdata_next, tblh_reg, tblh_next;
	logic we_reg, we_next, z_reg, z_next, c_reg, c_next, gie_reg, gie_next;
	logic [SP_W-1:0] sp_reg, sp_next;
	logic [PC_W-1:0] stack_reg [STACK_DEPTH];

	// ==========================================================
	// Decode and execute
	logic [OP_W-1:0] op;
	logic [DATA_W-1:0] imm, res;
	logic [SEL_W-1:0] sel;
	logic [DATA_W:0] sum9, diff9;
	logic to_mem, to_acc, z_we, c_we, c_val, skip, xfer, push, pop, tbl, commit;
	logic [PC_W-1:0] tgt;

	assign op = ir_reg[OP_LSB +: OP_W];
	assign imm = ir_reg[DATA_W-1:0];
	assign sel = ir_reg[SEL_LSB +: SEL_W];
	assign commit = (ph_reg == PH_LAST) && (st_reg == ICT_RUN);

	always_comb begin
		res = opnd_reg;
		to_mem = 1'b0;
		to_acc = 1'b0;
		z_we = 1'b0;
		c_we = 1'b0;
		c_val = c_reg;
		skip = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		tbl = 1'b0;
		tgt = ir_reg[PC_W-1:0];
		sum9 = {1'b0, acc_reg} + {1'b0, (op == OP_ADD_X) ? imm : opnd_reg};
		diff9 = {1'b0, acc_reg} - {1'b0, (op == OP_SUB_X) ? imm : opnd_reg};
		case (op)
			OP_LOAD_A_M: to_acc = 1'b1;
			OP_STORE_M_A: begin
				res = acc_reg;
				to_mem = 1'b1;
			end
			OP_LOAD_A_X: begin
				res = imm;
				to_acc = 1'b1;
			end
			OP_ADD_M, OP_ADD_X: begin
				res = sum9[DATA_W-1:0];
				c_val = sum9[DATA_W];
				c_we = 1'b1;
				z_we = 1'b1;
				to_mem = (op == OP_ADD_M) && ir_reg[DST_BIT];
				to_acc = !to_mem;
			end
			OP_SUB_M, OP_SUB_X: begin
				res = diff9[DATA_W-1:0];
				c_val = diff9[DATA_W];
				c_we = 1'b1;
				z_we = 1'b1;
				to_mem = (op == OP_SUB_M) && ir_reg[DST_BIT];
				to_acc = !to_mem;
			end
			OP_AND, OP_OR, OP_XOR, OP_COMPL: begin
				if (op == OP_AND) begin
					res = acc_reg & opnd_reg;
				end else if (op == OP_OR) begin
					res = acc_reg | opnd_reg;
				end else if (op == OP_XOR) begin
					res = acc_reg ^ opnd_reg;
				end else begin
					res = ~opnd_reg;
				end
				z_we = 1'b1;
				to_mem = ir_reg[DST_BIT];
				to_acc = !to_mem;
			end
			OP_INC, OP_DEC: begin
				res = (op == OP_INC) ? opnd_reg + DATA_ONE : opnd_reg - DATA_ONE;
				z_we = 1'b1;
				to_mem = ir_reg[DST_BIT];
				to_acc = !to_mem;
			end
			OP_ROR, OP_ROL, OP_RORC, OP_ROLC: begin
				if (op == OP_ROR) begin
					res = {opnd_reg[0], opnd_reg[DATA_W-1:1]};
				end else if (op == OP_ROL) begin
					res = {opnd_reg[DATA_W-2:0], opnd_reg[DATA_W-1]};
				end else if (op == OP_RORC) begin
					res = {c_reg, opnd_reg[DATA_W-1:1]};
					c_val = opnd_reg[0];
					c_we = 1'b1;
				end else begin
					res = {opnd_reg[DATA_W-2:0], c_reg};
					c_val = opnd_reg[DATA_W-1];
					c_we = 1'b1;
				end
				to_mem = ir_reg[DST_BIT];
				to_acc = !to_mem;
			end
			OP_SET: begin
				res = opnd_reg | bit_mask(sel);
				to_mem = 1'b1;
			end
			OP_CLR: begin
				res = opnd_reg & ~bit_mask(sel);
				to_mem = 1'b1;
			end
			OP_SZ: skip = (opnd_reg == DATA_ZERO);
			OP_SZ_BIT: skip = ((opnd_reg & bit_mask(sel)) == DATA_ZERO);
			OP_SNZ_BIT: skip = ((opnd_reg & bit_mask(sel)) != DATA_ZERO);
			OP_CALL: push = 1'b1;
			OP_EXIT, OP_IEXIT: begin
				pop = 1'b1;
				tgt = stack_reg[sp_reg - SP_W'(1)];
			end
			OP_TABRD: tbl = 1'b1;
			default: ;
		endcase
		// Any result landing on the low program counter byte is a jump
		if (to_mem && (imm == PC_LOW_ADDR)) begin
			tgt = {pc_reg[PC_W-1:DATA_W], res};
		end
		xfer = (op == OP_BRANCH) || push || pop || (to_mem && (imm == PC_LOW_ADDR));
	end

	// ==========================================================
	// Next state
	always_comb begin
		st_next = st_reg;
		ph_next = ph_reg + PH_W'(1);
		pc_next = pc_reg;
		paddr_next = paddr_reg;
		ir_next = ir_reg;
		opnd_next = opnd_reg;
		acc_next = acc_reg;
		daddr_next = daddr_reg;
		wdata_next = wdata_reg;
		tblh_next = tblh_reg;
		we_next = 1'b0;
		z_next = z_reg;
		c_next = c_reg;
		gie_next = gie_reg;
		sp_next = sp_reg;
		if (ph_reg == PH_READ) begin
			opnd_next = dmem_rdata_in;
		end
		// Write strobe stands for the last clock of the cycle only
		if (ph_reg == PH_WRITE) begin
			if ((st_reg == ICT_RUN) && to_mem) begin
				we_next = 1'b1;
				wdata_next = res;
			end else if (st_reg == ICT_TABLE) begin
				we_next = 1'b1;
				wdata_next = prog_data_in[DATA_W-1:0];
				tblh_next = prog_data_in[INSTR_W-1:DATA_W];
			end
		end
		if (ph_reg == PH_LAST) begin
			case (st_reg)
				ICT_TABLE: begin
					st_next = ICT_RUN;
					paddr_next = pc_reg;
					daddr_next = ir_reg[DATA_W-1:0];
				end
				default: begin
					ir_next = prog_data_in;
					pc_next = pc_reg + PC_W'(1);
					paddr_next = pc_reg + PC_W'(1);
					daddr_next = prog_data_in[DATA_W-1:0];
					st_next = ICT_RUN;
					if (st_reg == ICT_RUN) begin
						if (to_acc) begin
							acc_next = res;
						end
						if (z_we) begin
							z_next = (res == DATA_ZERO);
						end
						if (c_we) begin
							c_next = c_val;
						end
						if (op == OP_IEXIT || op == OP_IEN_SET) begin
							gie_next = 1'b1;
						end else if (op == OP_IEN_CLR) begin
							gie_next = 1'b0;
						end
						if (push) begin
							sp_next = sp_reg + SP_W'(1);
						end else if (pop) begin
							sp_next = sp_reg - SP_W'(1);
						end
						// Prefetched word is dropped; target is fetched in the spare cycle
						if (xfer) begin
							st_next = ICT_BUBBLE;
							pc_next = tgt;
							paddr_next = tgt;
						end else if (skip) begin
							st_next = ICT_BUBBLE;
						end else if (tbl) begin
							st_next = ICT_TABLE;
							paddr_next = {sel, acc_reg};
							daddr_next = imm;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_reg <= ICT_BUBBLE;
			ph_reg <= PH_FIRST;
			pc_reg <= PC_RESET;
			paddr_reg <= PC_RESET;
			ir_reg <= '0;
			opnd_reg <= DATA_ZERO;
			acc_reg <= DATA_ZERO;
			daddr_reg <= DATA_ZERO;
			wdata_reg <= DATA_ZERO;
			tblh_reg <= DATA_ZERO;
			we_reg <= 1'b0;
			z_reg <= 1'b0;
			c_reg <= 1'b0;
			gie_reg <= 1'b0;
			sp_reg <= '0;
		end else begin
			st_reg <= st_next;
			ph_reg <= ph_next;
			pc_reg <= pc_next;
			paddr_reg <= paddr_next;
			ir_reg <= ir_next;
			opnd_reg <= opnd_next;
			acc_reg <= acc_next;
			daddr_reg <= daddr_next;
			wdata_reg <= wdata_next;
			tblh_reg <= tblh_next;
			we_reg <= we_next;
			z_reg <= z_next;
			c_reg <= c_next;
			gie_reg <= gie_next;
			sp_reg <= sp_next;
		end
	end

	// Stack is not reset; overflow wraps and overwrites the oldest entry
	always_ff @(posedge clock_in) begin
		if (commit && push) begin
			stack_reg[sp_reg] <= pc_reg;
		end
	end

	assign prog_addr_out = paddr_reg;
	assign dmem_addr_out = daddr_reg;
	assign dmem_wdata_out = wdata_reg;
	assign dmem_we_out = we_reg;
	assign acc_out = acc_reg;
	assign zero_flag_out = z_reg;
	assign carry_flag_out = c_reg;
	assign global_interrupt_enable_out = gie_reg;
	assign table_high_out = tblh_reg;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!rst_n_in);

	property p_phase;
		ph_reg == PH_LAST |=> ph_reg == PH_FIRST ##1 ph_reg == PH_READ ##1 ph_reg == PH_WRITE;
	endproperty
	a_phase: assert property (p_phase) else $error("cycle is not four clocks");

	property p_single;
		commit && !xfer && !skip && !tbl |=> (st_reg == ICT_RUN) [*4];
	endproperty
	a_single: assert property (p_single) else $error("plain instruction lost a cycle");

	// Target held through the whole spare cycle, stack untouched
	property p_jump;
		commit && op == OP_BRANCH |=> st_reg == ICT_BUBBLE && paddr_reg == $past(tgt)
			&& sp_reg == $past(sp_reg) ##1 (st_reg == ICT_BUBBLE && $stable(paddr_reg)
			&& $stable(sp_reg)) [*3] ##1 st_reg == ICT_RUN;
	endproperty
	a_jump: assert property (p_jump) else $error("jump timing or target wrong");

	property p_call;
		commit && push |=> sp_reg == $past(sp_reg) + SP_W'(1) && paddr_reg == $past(tgt);
	endproperty
	a_call: assert property (p_call) else $error("call did not push");

	property p_skip;
		commit && skip && !xfer |=> st_reg == ICT_BUBBLE && pc_reg == $past(pc_reg) + PC_W'(1);
	endproperty
	a_skip: assert property (p_skip) else $error("taken skip not two cycles");

	property p_pc_low;
		commit && to_mem && imm == PC_LOW_ADDR |=> st_reg == ICT_BUBBLE
			&& paddr_reg[DATA_W-1:0] == $past(res);
	endproperty
	a_pc_low: assert property (p_pc_low) else $error("low counter write did not jump");

	property p_ret_gie;
		commit && op == OP_EXIT |=> gie_reg == $past(gie_reg);
	endproperty
	a_ret_gie: assert property (p_ret_gie) else $error("return changed enable");

	property p_interrupt_exit_gie;
		commit && op == OP_IEXIT |=> gie_reg;
	endproperty
	a_interrupt_exit_gie: assert property (p_interrupt_exit_gie) else $error("interrupt exit left enable low");

	property p_add_carry;
		commit && (op == OP_ADD_M || op == OP_ADD_X) |=> c_reg == ($past(sum9) > 9'h0ff);
	endproperty
	a_add_carry: assert property (p_add_carry) else $error("carry wrong after add");

	property p_bit_set;
		ph_reg == PH_WRITE && st_reg == ICT_RUN && op == OP_SET
			|=> we_reg && wdata_reg == ($past(opnd_reg) | bit_mask($past(sel)));
	endproperty
	a_bit_set: assert property (p_bit_set) else $error("bit force high disturbed others");

	c_jump: cover property (commit && op == OP_BRANCH);
	c_call: cover property (commit && op == OP_CALL);
	c_skip: cover property (commit && skip);
	c_table: cover property (st_reg == ICT_TABLE && we_reg);
endmodule
`default_nettype wire

// ### test/ict_mem_model.sv
// Program and data memories that sit beside the instruction cycle core.
// Assumes the bench preloads both arrays while the core is held in reset.
`timescale 1ns/1ps
`default_nettype none
module ict_mem_model (
	// Clock and answer speed
	input wire logic clock_in,
	input wire logic slow_in,
	// Program memory
	input wire logic [ict_pkg::PC_W-1:0] prog_addr_in,
	output logic [ict_pkg::INSTR_W-1:0] prog_data_out,
	// Data memory
	input wire logic [ict_pkg::DATA_W-1:0] dmem_addr_in,
	output logic [ict_pkg::DATA_W-1:0] dmem_rdata_out,
	input wire logic [ict_pkg::DATA_W-1:0] dmem_wdata_in,
	input wire logic dmem_we_in
);
	import ict_pkg::*;
	// ==========================================================
	// Storage
	logic [INSTR_W-1:0] pmem [0:(1<<PC_W)-1];
	logic [DATA_W-1:0] dmem [0:(1<<DATA_W)-1];
	logic [PC_W-1:0] paddr_reg;
	logic [DATA_W-1:0] daddr_reg;
	// ==========================================================
	// Answers; slow mode shows inverted data for one clock after a change
	assign prog_data_out = (slow_in && prog_addr_in != paddr_reg) ?
		~pmem[prog_addr_in] : pmem[prog_addr_in];
	assign dmem_rdata_out = (slow_in && dmem_addr_in != daddr_reg) ?
		~dmem[dmem_addr_in] : dmem[dmem_addr_in];
	always @(posedge clock_in) begin
		paddr_reg <= prog_addr_in;
		daddr_reg <= dmem_addr_in;
		if (dmem_we_in) begin
			dmem[dmem_addr_in] <= dmem_wdata_in;
		end
	end
endmodule
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench: core against an instruction-level model.
// Assumes ict_pkg, ict_core and ict_mem_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import ict_pkg::*;
	typedef struct {int fetch; int acc; int z; int c; int gie; int tbl;} ict_exp_type;
	logic clock_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic slow = 1'b0;
	logic [PC_W-1:0] prog_addr;
	logic [INSTR_W-1:0] prog_data;
	logic [DATA_W-1:0] dmem_addr, dmem_rdata, dmem_wdata, acc, tbl_hi;
	logic dmem_we, zero_flag, carry_flag, gie;
	int n_mismatch = 0;
	int check_count = 0;
	logic [INSTR_W-1:0] prog [0:2047];
	logic [DATA_W-1:0] dm0 [0:255];
	int dm [0:255];
	ict_exp_type exp_q [$];
	// Program as op, select, low byte
	int code [$] = '{OP_LOAD_A_X, 0, 8'h3c, OP_ADD_M, 1, 8'h10, OP_ADD_X, 0, 8'hf0,
		OP_SUB_M, 0, 8'h11, OP_SUB_X, 0, 8'h35, OP_AND, 0, 8'h12, OP_OR, 1, 8'h12,
		OP_XOR, 0, 8'h13, OP_COMPL, 1, 8'h14, OP_INC, 0, 8'h15, OP_DEC, 1, 8'h15,
		OP_ROR, 1, 8'h16, OP_ROL, 0, 8'h16, OP_RORC, 1, 8'h17, OP_ROLC, 0, 8'h17,
		OP_SET, 3, 8'h18, OP_CLR, 5, 8'h18, OP_STORE_M_A, 0, 8'h19, OP_LOAD_A_M, 0, 8'h1a,
		OP_SZ, 0, 8'h1b, OP_LOAD_A_X, 0, 8'h55, OP_SZ, 0, 8'h1c, OP_SZ_BIT, 2, 8'h1d,
		OP_SNZ_BIT, 2, 8'h1d, OP_CALL, 0, 8'h28, OP_CALL, 0, 8'h29, OP_CALL, 0, 8'h28,
		OP_IEN_CLR, 0, 0, OP_IEN_SET, 0, 0, OP_TABRD, 1, 8'h1e, OP_LOAD_A_X, 0, 8'h3c,
		OP_STORE_M_A, 0, 8'h06};
	always #12.5 clock_in = ~clock_in;
	// ==========================================================
	// Design and memories
	ict_core #(.STACK_DEPTH(8)) ict_core_i (.clock_in(clock_in), .rst_n_in(rst_n_in),
		.prog_addr_out(prog_addr), .prog_data_in(prog_data), .dmem_addr_out(dmem_addr),
		.dmem_rdata_in(dmem_rdata), .dmem_wdata_out(dmem_wdata), .dmem_we_out(dmem_we),
		.acc_out(acc), .zero_flag_out(zero_flag), .carry_flag_out(carry_flag),
		.global_interrupt_enable_out(gie), .table_high_out(tbl_hi));
	ict_mem_model ict_mem_model_i (.clock_in(clock_in), .slow_in(slow),
		.prog_addr_in(prog_addr), .prog_data_out(prog_data), .dmem_addr_in(dmem_addr),
		.dmem_rdata_out(dmem_rdata), .dmem_wdata_in(dmem_wdata), .dmem_we_in(dmem_we));
	// ==========================================================
	// Checking and verdict
	task automatic chk(input logic [15:0] seen, input logic [15:0] expv, input string what);
		check_count++;
		if (seen !== expv) begin
			n_mismatch++;
			$display("FAIL %0t %s seen %h expected %h", $time, what, seen, expv);
		end
	endtask
	task automatic results();
		if (n_mismatch == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// ==========================================================
	// Reference model, one entry per instruction cycle
	task automatic iss();
		int pc = 0, ac = 0, z = 0, c = 0, g = 0, tb = 0;
		int a, op, sel, m, r, nxt, t, dst;
		int stk [$];
		exp_q = {};
		exp_q.push_back('{0, 0, 0, 0, 0, 0});
		while (exp_q.size() < 80) begin
			op = int'(prog[pc][15:11]);
			sel = int'(prog[pc][10:8]);
			a = int'(prog[pc][7:0]);
			m = dm[a];
			r = -1;
			nxt = -1;
			dst = (op == OP_STORE_M_A || op == OP_SET || op == OP_CLR) ? 1 : sel & 1;
			exp_q.push_back('{pc + 1, ac, z, c, g, tb});
			case (op)
				OP_LOAD_A_M: ac = m;
				OP_STORE_M_A: r = ac;
				OP_LOAD_A_X: ac = a;
				OP_ADD_M, OP_ADD_X: begin
					r = ac + ((op == OP_ADD_M) ? m : a);
					c = r >> 8;
				end
				OP_SUB_M, OP_SUB_X: begin
					t = (op == OP_SUB_M) ? m : a;
					c = (ac < t);
					r = (ac - t) & 255;
				end
				OP_AND: r = ac & m;
				OP_OR: r = ac | m;
				OP_XOR: r = ac ^ m;
				OP_COMPL: r = ~m & 255;
				OP_INC: r = (m + 1) & 255;
				OP_DEC: r = (m + 255) & 255;
				OP_ROR: r = (m >> 1) | ((m & 1) << 7);
				OP_ROL: r = ((m << 1) & 255) | (m >> 7);
				OP_RORC: begin
					r = (m >> 1) | (c << 7);
					c = m & 1;
				end
				OP_ROLC: begin
					r = ((m << 1) & 255) | c;
					c = m >> 7;
				end
				OP_SET: r = m | (1 << sel);
				OP_CLR: r = m & ~(1 << sel);
				OP_SZ: if (m == 0) nxt = pc + 2;
				OP_SZ_BIT: if (((m >> sel) & 1) == 0) nxt = pc + 2;
				OP_SNZ_BIT: if (((m >> sel) & 1) == 1) nxt = pc + 2;
				OP_BRANCH: nxt = int'(prog[pc][10:0]);
				OP_CALL: begin
					stk.push_back(pc + 1);
					nxt = int'(prog[pc][10:0]);
				end
				OP_EXIT: nxt = stk.pop_back();
				OP_IEXIT: begin
					nxt = stk.pop_back();
					g = 1;
				end
				OP_TABRD: begin
					t = int'(prog[(sel << 8) | ac]);
					dm[a] = t & 255;
					exp_q.push_back('{-1, ac, z, c, g, -1});
					tb = t >> 8;
				end
				OP_IEN_CLR: g = 0;
				OP_IEN_SET: g = 1;
				default: ;
			endcase
			if (op >= OP_ADD_M && op <= OP_DEC) z = ((r & 255) == 0);
			if (r >= 0) begin
				r = r & 255;
				if (dst == 1) dm[a] = r;
				if (dst == 1 && a == 6) nxt = r;
				if (dst == 0) ac = r;
			end
			if (nxt >= 0) begin
				exp_q.push_back('{nxt, ac, z, c, g, tb});
				pc = nxt;
			end else begin
				pc++;
			end
		end
	endtask
	// ==========================================================
	// One run from reset, sampling mid-cycle
	task automatic run(input logic slow_v);
		ict_exp_type e;
		slow <= slow_v;
		rst_n_in <= 1'b0;
		foreach (dm0[i]) dm[i] = int'(dm0[i]);
		foreach (dm0[i]) ict_mem_model_i.dmem[i] = dm0[i];
		foreach (prog[i]) ict_mem_model_i.pmem[i] = prog[i];
		repeat (3) @(posedge clock_in);
		rst_n_in <= 1'b1;
		iss();
		repeat (2) @(posedge clock_in);
		foreach (exp_q[i]) begin
			e = exp_q[i];
			#1;
			if (e.fetch >= 0) chk(16'(prog_addr), 16'(e.fetch), "fetch");
			chk(16'(acc), 16'(e.acc), "acc");
			chk(16'(zero_flag), 16'(e.z), "zero");
			chk(16'(carry_flag), 16'(e.c), "carry");
			chk(16'(gie), 16'(e.gie), "enable");
			if (e.tbl >= 0) chk(16'(tbl_hi), 16'(e.tbl), "table");
			repeat (4) @(posedge clock_in);
		end
		for (int i = 0; i < 32; i++) chk(16'(ict_mem_model_i.dmem[i]), 16'(dm[i]), "dmem");
	endtask
	initial begin
		void'($urandom(55533));
		foreach (prog[i]) prog[i] = 16'($urandom());
		foreach (dm0[i]) dm0[i] = 8'($urandom());
		dm0[8'h1b] = 8'h00;
		dm0[8'h1c] = dm0[8'h1c] | 8'h01;
		for (int k = 0; k < code.size() / 3; k++) begin
			prog[k] = 16'((code[3*k] << 11) | (code[3*k+1] << 8) | code[3*k+2]);
		end
		prog[40] = {OP_EXIT, 11'h000};
		prog[41] = {OP_IEXIT, 11'h000};
		prog[60] = {OP_BRANCH, 11'h03c};
		run(1'b0);
		run(1'b1);
		results();
	end
endmodule
`default_nettype wire
